/* File: src/unified_io_regs.vh */
`ifndef UNIFIED_IO_REGS_VH
`define UNIFIED_IO_REGS_VH

// byte offsets of the register window
`define SET_OUTPUT_DATA_OFS 12'h030
`define PIN_LEVEL_STATUS_OFS 12'h030
`define PIN_LEVEL_ALIAS_OFS 12'h03C
`define CLEAR_OUTPUT_DATA_OFS 12'h034
`define OUTPUT_DATA_STATUS_OFS 12'h038
`define OPEN_DRAIN_ENABLE_OFS 12'h040
`define OPEN_DRAIN_DISABLE_OFS 12'h044
`define OPEN_DRAIN_STATUS_OFS 12'h048
`define CLOCK_ENABLE_OFS 12'h050
`define CLOCK_DISABLE_OFS 12'h054
`define CLOCK_POWER_STATUS_OFS 12'h058

// address bits decoded inside the window
`define ADDR_MSB 11

// implemented lines, one bit each
`define LINE_MASK 32'hFFFFFFFF

// field position of the controller clock bit
`define CONTROLLER_CLOCK_BIT 0

// reset values
`define OUTPUT_DATA_RST 32'h00000000
`define OPEN_DRAIN_RST 32'h00000000
`define CLOCK_ON_RST 1'b0

// ahb-lite encodings
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define HSIZE_WORD 3'b010
`define HRESP_OKAY 1'b0

`endif

/* File: src/unified_io_controller.v */
// Summary of operation
// - writing one to a set_output_data bit drives that line's data latch high
// - writing one to a clear_output_data bit drives that latch low; zeros ignored
// - output_data_status reads back every line's programmed data latch
// - pin_level_status reads the level present on each pad, sampled only while the controller clock runs
// - writing one to an open_drain_enable bit makes that line open drain
// - writing one to an open_drain_disable bit returns that line to push-pull
// - open_drain_status reads one for each open-drain line
// - writing one to bit 0 of clock_enable switches the controller clock on
// - writing one to bit 0 of clock_disable switches the controller clock off
// - bit 0 of clock_power_status reads one while the controller clock runs
// - programmed data reaches a pad only while that line is selected as output
// - an open-drain line only pulls low and releases the pad for a one
// - writes to absent lines do nothing and those bits read zero
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "unified_io_regs.vh"

module unified_io_controller
(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg [31:0] hrdata,
    output reg hresp,
    input wire [31:0] line_output_select,
    input wire [31:0] line_bit_in,
    output reg [31:0] line_bit_out,
    output reg [31:0] line_bit_oe,
    output reg controller_clock_on
);

    reg [31:0] out_data_ff;
    reg [31:0] nxt_out_data;
    reg [31:0] open_drain_ff;
    reg [31:0] nxt_open_drain;
    reg clock_on_ff;
    reg nxt_clock_on;
    reg [31:0] pin_level_ff;
    reg wr_pend_ff;
    reg [`ADDR_MSB:0] wr_addr_ff;
    reg [31:0] nxt_rdata;
    reg [31:0] wmask;
    wire take;
    wire rd_take;

    // a transfer is taken when the previous one completes and a NONSEQ or SEQ access is offered; hsize is not checked
    assign take = hsel & hready & htrans[1];
    assign rd_take = take & ~hwrite;

    function [31:0] word_if;
        input [`ADDR_MSB:0] addr;
        input [`ADDR_MSB:0] ofs;
        input [31:0] data;
        begin
            word_if = (addr == ofs) ? data : 32'h00000000;
        end
    endfunction

    // the write applies in the data phase; the new state is also what a read
    // issued in that same cycle sees, so read-after-write needs no wait state
    always @*
    begin
        wmask = wr_pend_ff ? (hwdata & `LINE_MASK) : 32'h00000000;
        nxt_out_data = out_data_ff;
        nxt_open_drain = open_drain_ff;
        nxt_clock_on = clock_on_ff;
        case (wr_addr_ff)
            `SET_OUTPUT_DATA_OFS:
                nxt_out_data = out_data_ff | wmask;
            `CLEAR_OUTPUT_DATA_OFS:
                nxt_out_data = out_data_ff & ~wmask;
            `OPEN_DRAIN_ENABLE_OFS:
                nxt_open_drain = open_drain_ff | wmask;
            `OPEN_DRAIN_DISABLE_OFS:
                nxt_open_drain = open_drain_ff & ~wmask;
            `CLOCK_ENABLE_OFS:
                if (wmask[`CONTROLLER_CLOCK_BIT])
                begin
                    nxt_clock_on = 1'b1;
                end
            `CLOCK_DISABLE_OFS:
                if (wmask[`CONTROLLER_CLOCK_BIT])
                begin
                    nxt_clock_on = 1'b0;
                end
            default:
                nxt_out_data = out_data_ff;
        endcase
    end

    // write-only offsets and holes read zero
    always @*
    begin
        nxt_rdata = word_if(haddr[`ADDR_MSB:0], `PIN_LEVEL_STATUS_OFS, pin_level_ff)
            | word_if(haddr[`ADDR_MSB:0], `PIN_LEVEL_ALIAS_OFS, pin_level_ff)
            | word_if(haddr[`ADDR_MSB:0], `OUTPUT_DATA_STATUS_OFS, nxt_out_data)
            | word_if(haddr[`ADDR_MSB:0], `OPEN_DRAIN_STATUS_OFS, nxt_open_drain)
            | word_if(haddr[`ADDR_MSB:0], `CLOCK_POWER_STATUS_OFS,
                {31'h00000000, nxt_clock_on});
        nxt_rdata = nxt_rdata & `LINE_MASK;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            out_data_ff <= `OUTPUT_DATA_RST;
            open_drain_ff <= `OPEN_DRAIN_RST;
            clock_on_ff <= `CLOCK_ON_RST;
            pin_level_ff <= 32'h00000000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h000;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= `HRESP_OKAY;
            line_bit_out <= 32'h00000000;
            line_bit_oe <= 32'h00000000;
            controller_clock_on <= `CLOCK_ON_RST;
        end
        else
        begin
            out_data_ff <= nxt_out_data;
            open_drain_ff <= nxt_open_drain;
            clock_on_ff <= nxt_clock_on;
            controller_clock_on <= nxt_clock_on;
            // sampling stops with the controller clock; the last level is held
            if (clock_on_ff)
            begin
                pin_level_ff <= line_bit_in;
            end
            wr_pend_ff <= take & hwrite;
            wr_addr_ff <= haddr[`ADDR_MSB:0];
            hreadyout <= 1'b1;
            hresp <= `HRESP_OKAY;
            if (rd_take)
            begin
                hrdata <= nxt_rdata;
            end
            // open drain: drive low only, release for one; push-pull drives both levels
            line_bit_out <= nxt_out_data & ~nxt_open_drain;
            line_bit_oe <= line_output_select
                & (~nxt_open_drain | ~nxt_out_data) & `LINE_MASK;
        end
    end

endmodule

/* File: tb/unified_io_checker_sva.sv */
`timescale 1ns/1ps
module unified_io_checker
(
    input hclk,
    input hresetn,
    input hsel,
    input [31:0] haddr,
    input [1:0] htrans,
    input hwrite,
    input hreadyout,
    input [31:0] hrdata,
    input hresp,
    input [31:0] line_output_select,
    input [31:0] line_bit_out,
    input [31:0] line_bit_oe,
    input controller_clock_on
);
    wire [11:0] a = haddr[11:0];
    wire tk = hsel & hreadyout & htrans[1], rd = tk & ~hwrite, wr = tk & hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_rdy;
        hreadyout;
    endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
    property p_resp;
        hresp == 1'b0;
    endproperty
    a_resp: assert property (p_resp) else $error("response not okay");
    property p_sel;
        (line_bit_oe & ~$past(line_output_select)) == 32'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("drive");
    property p_od;
        (line_bit_out & ~line_bit_oe & $past(line_output_select)) == 32'h0;
    endproperty
    a_od: assert property (p_od) else $error("od");
    property p_clk;
        $changed(controller_clock_on) |-> $past(wr, 2);
    endproperty
    a_clk: assert property (p_clk) else $error("clock");
    property p_out;
        $changed(line_bit_out) |-> $past(wr, 2);
    endproperty
    a_out: assert property (p_out) else $error("out");
    property p_pm;
        rd && a == 12'h058 |=> hrdata == {31'h0, controller_clock_on};
    endproperty
    a_pm: assert property (p_pm) else $error("pm");
    property p_hole;
        rd && a == 12'h034 |=> hrdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("hole");
    property p_hold;
        $changed(hrdata) |-> $past(rd);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
endmodule
bind unified_io_controller unified_io_checker u_unified_io_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hreadyout, .hrdata, .hresp, .line_output_select, .line_bit_out, .line_bit_oe, .controller_clock_on);

/* File: tb/pad_model.sv */
`timescale 1ns/1ps
module pad_model
#(parameter logic [31:0] ext_level = 32'hFFFFFFFF)
(
    input [31:0] drv,
    input [31:0] oe,
    output [31:0] pad
);
    // released lines show the outside level, all ones where only the pull-up acts
    assign pad = (oe & drv) | (~oe & ext_level);
endmodule

/* File: tb/test_unified_io_controller.sv */
`timescale 1ns/1ps
module test_unified_io_controller;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire ck, rsp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    wire rdy;
    wire [31:0] rdata, pad, dout, doe;
    int n_errors = 0, comparisons = 0;
    localparam logic [31:0] sel = 32'hFFFF00FF, ext = 32'h1234F678, dat = 32'hA5A5000F, od = 32'hF0FF0000;
    localparam logic [31:0] e_oe = sel & ~(od & dat), e_pad = (e_oe & dat & ~od) | (~e_oe & ext);
    always #20 hclk = ~hclk;
    unified_io_controller u_unified_io_controller (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(rdy), .hreadyout(rdy), .hrdata(rdata), .hresp(rsp), .line_output_select(sel),
        .line_bit_in(pad), .line_bit_out(dout), .line_bit_oe(doe), .controller_clock_on(ck));
    pad_model #(.ext_level(ext)) u_pad_model (.drv(dout), .oe(doe), .pad(pad));
    task automatic print_verdict();
        $display("errors %0d of %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        n_errors += (got !== exp);
        if (got !== exp) $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    endtask
    // bounded wait for hready, a hang ends the run
    task automatic wt();
        int n = 0;
        do @(posedge hclk); while (rdy !== 1'h1 && ++n < 99);
        if (rdy !== 1'h1)
        begin
            chk(32'h0, 32'h1);
            print_verdict();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, 20'h0, a};
        wt();
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        wt();
        if (!w) chk(rdata, d);
    endtask
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, 12'h058, 32'h0);
        bus(1'h1, 12'h030, 32'hA5A5F00F);
        bus(1'h1, 12'h034, 32'h0000F000);
        bus(1'h0, 12'h038, dat);
        bus(1'h1, 12'h040, 32'hFFFF0000);
        bus(1'h1, 12'h044, 32'h0F000000);
        bus(1'h0, 12'h048, od);
        chk(doe, e_oe);
        chk(dout, dat & ~od);
        bus(1'h1, 12'h050, 32'h1);
        bus(1'h0, 12'h058, 32'h1);
        chk({31'h0, ck}, 32'h1);
        chk({31'h0, rsp}, 32'h0);
        bus(1'h0, 12'h030, e_pad);
        bus(1'h1, 12'h054, 32'h1);
        bus(1'h0, 12'h058, 32'h0);
        chk({31'h0, ck}, 32'h0);
        bus(1'h0, 12'h034, 32'h0);
        print_verdict();
    end
endmodule
